// *** include/csc_cfg.svh ***
// Purpose: Offsets, field positions, reset values of the control regs
// Assumes: Byte addresses on a 32-bit AHB-Lite bus, one word per register
// Notes:   Definitions only
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH

////////////////////////////////////////////////////////////////////////////
// Register byte offsets (low address byte only)
`define CSC_OFF_ID      8'h00
`define CSC_OFF_INTERRUPT_CONTROL_STATE    8'h04
`define CSC_OFF_VECTOR_TABLE_OFFSET    8'h08
`define CSC_OFF_AUX     8'h20

////////////////////////////////////////////////////////////////////////////
// Auxiliary control fields
`define CSC_AUX_OOFP    9
`define CSC_AUX_FPCA    8
`define CSC_AUX_FOLD    2
`define CSC_AUX_WBUF    1
`define CSC_AUX_MCYC    0
`define CSC_AUX_RST     32'h0000_0000

////////////////////////////////////////////////////////////////////////////
// Interrupt control and state fields
`define CSC_INTERRUPT_CONTROL_STATE_NMI    31
`define CSC_INTERRUPT_CONTROL_STATE_SVSET  28
`define CSC_INTERRUPT_CONTROL_STATE_SVCLR  27
`define CSC_INTERRUPT_CONTROL_STATE_STSET  26
`define CSC_INTERRUPT_CONTROL_STATE_STCLR  25
`define CSC_INTERRUPT_CONTROL_STATE_ISRP   22
`define CSC_INTERRUPT_CONTROL_STATE_VP_HI  18
`define CSC_INTERRUPT_CONTROL_STATE_VP_LO  12
`define CSC_INTERRUPT_CONTROL_STATE_RTB    11
`define CSC_INTERRUPT_CONTROL_STATE_VA_HI  8
`define CSC_INTERRUPT_CONTROL_STATE_RST    32'h0000_0000

////////////////////////////////////////////////////////////////////////////
// Vector table offset fields
`define CSC_VECTOR_TABLE_OFFSET_HI     29
`define CSC_VECTOR_TABLE_OFFSET_LO     9
`define CSC_VECTOR_TABLE_OFFSET_RST    32'h0000_0000

`endif

// *** include/csc_pkg.sv ***
// Purpose: Types shared by the system control register block
// Assumes: Offsets and fields live in csc_cfg.svh
// Notes:   One-hot codes written out
`default_nettype none

package csc_pkg;

    // Data phase of the bus slave
    typedef enum logic [2:0] {
        PH_IDLE  = 3'b001,
        PH_WRITE = 3'b010,
        PH_READ  = 3'b100
    } csc_phase_t;

endpackage

`default_nettype wire

// *** rtl/csc_regs.sv ***
// Purpose: System control registers: aux control, identification,
//          interrupt control and state, vector table offset
// Assumes: AHB-Lite slave on core_clk; core status inputs on core_clk
// Notes:   Writes take no wait state, reads take one
`include "csc_cfg.svh"
`default_nettype none

module csc_regs #(
    // Identification values, arbitrary
    parameter logic [7:0]  ID_IMPLEMENTER = 8'h5A,
    parameter logic [3:0]  ID_VARIANT     = 4'h3,
    parameter logic [3:0]  ID_CONSTANT    = 4'h7,
    parameter logic [11:0] ID_PART        = 12'h9B2,
    parameter logic [3:0]  ID_REVISION    = 4'h2
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Core exception status
    input  wire logic        nmiRequest,
    input  wire logic        nmiEntry,
    input  wire logic        pendSvEntry,
    input  wire logic        tickEvent,
    input  wire logic        tickEntry,
    input  wire logic        anyIrqPending,
    input  wire logic [6:0]  highestPending,
    input  wire logic        returnToBase,
    input  wire logic [8:0]  activeNumber,
    // Core controls
    output logic             fpInOrderForce,
    output logic             fpContextFlagFreeze,
    output logic             ifthenFoldDisable,
    output logic             writeBufferDisable,
    output logic             multicycleIntDisable,
    output logic             nmiPending,
    output logic             pendSvPending,
    output logic             tickPending,
    output logic [20:0]      tableBaseOffset,
    output logic             tableRegionSram
);

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    csc_pkg::csc_phase_t phase_reg;
    csc_pkg::csc_phase_t phase_next;
    logic [7:0]  addr_reg;
    logic [31:0] rdMux;
    logic [4:0]  aux_reg;
    logic [20:0] vector_table_offset_reg;
    logic        nmiPend_reg;
    logic        svPend_reg;
    logic        tickPend_reg;
    logic        hready_reg;
    logic [31:0] hrdata_reg;
    localparam logic [31:0] AUX_RST  = `CSC_AUX_RST;
    localparam logic [31:0] VECTOR_TABLE_OFFSET_RST = `CSC_VECTOR_TABLE_OFFSET_RST;

    wire accept   = hsel & htrans[1] & hready;
    wire rdAccept = accept & ~hwrite;
    wire wrPhase  = (phase_reg == csc_pkg::PH_WRITE) & hready;
    wire wrAux    = wrPhase & (addr_reg == `CSC_OFF_AUX);
    wire wrIcsr   = wrPhase & (addr_reg == `CSC_OFF_INTERRUPT_CONTROL_STATE);
    wire wrVtor   = wrPhase & (addr_reg == `CSC_OFF_VECTOR_TABLE_OFFSET);

    wire nmiSetSw  = wrIcsr & hwdata[`CSC_INTERRUPT_CONTROL_STATE_NMI];
    wire svSetSw   = wrIcsr & hwdata[`CSC_INTERRUPT_CONTROL_STATE_SVSET];
    wire svClrSw   = wrIcsr & hwdata[`CSC_INTERRUPT_CONTROL_STATE_SVCLR];
    wire tickSetSw = wrIcsr & hwdata[`CSC_INTERRUPT_CONTROL_STATE_STSET];
    wire tickClrSw = wrIcsr & hwdata[`CSC_INTERRUPT_CONTROL_STATE_STCLR];

    ////////////////////////////////////////////////////////////////////////
    // Pending state: a set in the same cycle as a clear wins, so an
    // event arriving during handler entry is never dropped
    wire nmiNext  = nmiSetSw | nmiRequest |
                    (nmiPend_reg & ~nmiEntry);
    wire svNext   = svSetSw |
                    (svPend_reg & ~svClrSw & ~pendSvEntry);
    wire tickNext = tickSetSw | tickEvent |
                    (tickPend_reg & ~tickClrSw & ~tickEntry);

    ////////////////////////////////////////////////////////////////////////
    // Read mux; write-only and reserved bits read zero
    wire [31:0] idWord = {ID_IMPLEMENTER, ID_VARIANT, ID_CONSTANT,
                          ID_PART, ID_REVISION};

    always_comb begin
        rdMux = 32'h0000_0000;
        case (addr_reg)
            `CSC_OFF_ID: begin
                rdMux = idWord;
            end
            `CSC_OFF_AUX: begin
                rdMux[`CSC_AUX_OOFP] = fpInOrderForce;
                rdMux[`CSC_AUX_FPCA] = fpContextFlagFreeze;
                rdMux[`CSC_AUX_FOLD] = ifthenFoldDisable;
                rdMux[`CSC_AUX_WBUF] = writeBufferDisable;
                rdMux[`CSC_AUX_MCYC] = multicycleIntDisable;
            end
            `CSC_OFF_INTERRUPT_CONTROL_STATE: begin
                rdMux[`CSC_INTERRUPT_CONTROL_STATE_NMI]   = nmiPend_reg;
                rdMux[`CSC_INTERRUPT_CONTROL_STATE_SVSET] = svPend_reg;
                rdMux[`CSC_INTERRUPT_CONTROL_STATE_STSET] = tickPend_reg;
                rdMux[`CSC_INTERRUPT_CONTROL_STATE_ISRP]  = anyIrqPending;
                rdMux[`CSC_INTERRUPT_CONTROL_STATE_VP_HI:`CSC_INTERRUPT_CONTROL_STATE_VP_LO]
                    = highestPending;
                rdMux[`CSC_INTERRUPT_CONTROL_STATE_RTB]   = returnToBase;
                rdMux[`CSC_INTERRUPT_CONTROL_STATE_VA_HI:0] = activeNumber;
            end
            `CSC_OFF_VECTOR_TABLE_OFFSET: begin
                rdMux[`CSC_VECTOR_TABLE_OFFSET_HI:`CSC_VECTOR_TABLE_OFFSET_LO] = vector_table_offset_reg;
            end
            default: begin
                rdMux = 32'h0000_0000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Data phase sequencer
    always_comb begin
        phase_next = phase_reg;
        case (phase_reg)
            csc_pkg::PH_IDLE, csc_pkg::PH_WRITE: begin
                if (accept) begin
                    phase_next = hwrite ? csc_pkg::PH_WRITE
                                        : csc_pkg::PH_READ;
                end else begin
                    phase_next = csc_pkg::PH_IDLE;
                end
            end
            csc_pkg::PH_READ: begin
                phase_next = csc_pkg::PH_IDLE;
            end
            default: begin
                phase_next = csc_pkg::PH_IDLE;
            end
        endcase
    end

    // Read data is taken one cycle late so a write just before is seen
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            phase_reg  <= csc_pkg::PH_IDLE;
            addr_reg   <= 8'h00;
            hready_reg <= 1'b1;
            hrdata_reg <= 32'h0000_0000;
        end else begin
            phase_reg  <= phase_next;
            hready_reg <= ~rdAccept;
            if (accept) begin
                addr_reg <= haddr[7:0];
            end
            if (phase_reg == csc_pkg::PH_READ) begin
                hrdata_reg <= rdMux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register state
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            aux_reg      <= {AUX_RST[`CSC_AUX_OOFP:`CSC_AUX_FPCA],
                             AUX_RST[`CSC_AUX_FOLD:`CSC_AUX_MCYC]};
            vector_table_offset_reg     <= VECTOR_TABLE_OFFSET_RST[`CSC_VECTOR_TABLE_OFFSET_HI:`CSC_VECTOR_TABLE_OFFSET_LO];
            nmiPend_reg  <= 1'b0;
            svPend_reg   <= 1'b0;
            tickPend_reg <= 1'b0;
        end else begin
            if (wrAux) begin
                aux_reg <= {hwdata[`CSC_AUX_OOFP:`CSC_AUX_FPCA],
                            hwdata[`CSC_AUX_FOLD:`CSC_AUX_MCYC]};
            end
            if (wrVtor) begin
                vector_table_offset_reg <= hwdata[`CSC_VECTOR_TABLE_OFFSET_HI:`CSC_VECTOR_TABLE_OFFSET_LO];
            end
            nmiPend_reg  <= nmiNext;
            svPend_reg   <= svNext;
            tickPend_reg <= tickNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign hreadyout            = hready_reg;
    assign hresp                = 1'b0;
    assign hrdata               = hrdata_reg;
    assign fpInOrderForce       = aux_reg[4];
    assign fpContextFlagFreeze  = aux_reg[3];
    assign ifthenFoldDisable    = aux_reg[2];
    assign writeBufferDisable   = aux_reg[1];
    assign multicycleIntDisable = aux_reg[0];
    assign nmiPending           = nmiPend_reg;
    assign pendSvPending        = svPend_reg;
    assign tickPending          = tickPend_reg;
    assign tableBaseOffset      = vector_table_offset_reg;
    assign tableRegionSram      = vector_table_offset_reg[20];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    wire rdIcsr = rdAccept & (haddr[7:0] == `CSC_OFF_INTERRUPT_CONTROL_STATE);
    wire rdAux  = rdAccept & (haddr[7:0] == `CSC_OFF_AUX);
    wire rdId   = rdAccept & (haddr[7:0] == `CSC_OFF_ID);
    wire rdVtor = rdAccept & (haddr[7:0] == `CSC_OFF_VECTOR_TABLE_OFFSET);

    AST_NMI_SET: assert property (
        nmiSetSw |=> nmiPending ##0 nmiPend_reg)
        else $error("nmi pending not set by write");

    AST_NMI_ENTRY_CLR: assert property (
        nmiEntry && !nmiRequest && !nmiSetSw |=> !nmiPending)
        else $error("nmi pending not cleared on entry");

    AST_SV_ONLY_SW: assert property (
        $rose(pendSvPending) |-> $past(svSetSw))
        else $error("service pending set without write");

    AST_SV_CLR: assert property (
        svClrSw && !svSetSw |=> !pendSvPending)
        else $error("service pending not cleared");

    AST_TICK_SET: assert property (
        tickSetSw || tickEvent |=> tickPending [*1] ##0 tickPend_reg)
        else $error("tick pending not set");

    AST_TICK_CLR: assert property (
        (tickClrSw || tickEntry) && !tickSetSw && !tickEvent
        |=> !tickPending)
        else $error("tick pending not cleared");

    AST_INTERRUPT_CONTROL_STATE_PENDNUM: assert property (
        rdIcsr |=> !hreadyout ##1 (hreadyout &&
        hrdata[18:12] == $past(highestPending) &&
        hrdata[8:0] == $past(activeNumber)))
        else $error("pending or active number misreported");

    AST_AUX_FOLD: assert property (
        wrAux |=> ifthenFoldDisable == $past(hwdata[2]) &&
        fpInOrderForce == $past(hwdata[9]))
        else $error("aux control write not applied");

    AST_AUX_READ: assert property (
        rdAux |=> ##1 hrdata[31:10] == 22'h00_0000 &&
        hrdata[7:3] == 5'h00)
        else $error("reserved aux bits read nonzero");

    AST_VECTOR_TABLE_OFFSET_WRITE: assert property (
        wrVtor |=> tableBaseOffset == $past(hwdata[29:9]) &&
        tableRegionSram == $past(hwdata[29]))
        else $error("vector offset write not applied");

    AST_AUX_RESET: assert property (
        $rose(rst_n) |-> !fpInOrderForce && !fpContextFlagFreeze &&
        !ifthenFoldDisable && !writeBufferDisable && !multicycleIntDisable)
        else $error("aux control not zero after reset");

    AST_AUX_FPCA: assert property (
        wrAux |=> fpContextFlagFreeze == $past(hwdata[8]))
        else $error("context flag freeze bit not applied");

    AST_AUX_WBUF: assert property (
        wrAux |=> writeBufferDisable == $past(hwdata[1]))
        else $error("write buffer disable bit not applied");

    AST_AUX_MCYC: assert property (
        wrAux |=> multicycleIntDisable == $past(hwdata[0]))
        else $error("multicycle interrupt disable bit not applied");

    AST_SV_SET: assert property (
        svSetSw |=> pendSvPending)
        else $error("service pending not set by write");

    AST_ID_READ: assert property (
        rdId |=> ##1 hrdata == {ID_IMPLEMENTER, ID_VARIANT, ID_CONSTANT,
        ID_PART, ID_REVISION})
        else $error("identification word misreported");

    AST_INTERRUPT_CONTROL_STATE_PEND: assert property (
        rdIcsr |=> ##1 hrdata[31] == $past(nmiPending) &&
        hrdata[28] == $past(pendSvPending) &&
        hrdata[26] == $past(tickPending))
        else $error("pending flags misreported");

    AST_INTERRUPT_CONTROL_STATE_ISRP: assert property (
        rdIcsr |=> ##1 hrdata[22] == $past(anyIrqPending))
        else $error("any pending flag misreported");

    AST_INTERRUPT_CONTROL_STATE_RTB: assert property (
        rdIcsr |=> ##1 hrdata[11] == $past(returnToBase))
        else $error("return to base flag misreported");

    AST_INTERRUPT_CONTROL_STATE_ZERO: assert property (
        rdIcsr |=> ##1 hrdata[30:29] == 2'b00 && hrdata[27] == 1'b0 &&
        hrdata[25:23] == 3'b000 && hrdata[21:19] == 3'b000 &&
        hrdata[10:9] == 2'b00)
        else $error("write-only or reserved status bits read nonzero");

    AST_VECTOR_TABLE_OFFSET_READ: assert property (
        rdVtor |=> ##1 hrdata[31:30] == 2'b00 && hrdata[8:0] == 9'h000)
        else $error("reserved vector offset bits read nonzero");

    COV_READ_INTERRUPT_CONTROL_STATE: cover property (rdIcsr ##2 hreadyout);
    COV_NMI_REENTRY: cover property (nmiEntry && nmiRequest);
    COV_SV_SET_CLR: cover property (svSetSw ##[1:8] svClrSw);
    COV_TICK_HW: cover property (tickEvent && !tickPending);

endmodule

`default_nettype wire

// *** testbench/tb_top.sv ***
// Purpose: Self-checking bench for the system control register block
// Assumes: One AHB-Lite slave, hready looped back from hreadyout
// Notes:   A monitor checks read data against a queue of expectations
`include "csc_cfg.svh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // Identification values, arbitrary
    localparam logic [31:0] ID_EXP = 32'h5A37_9B22;
    localparam logic [7:0]  REGS [5] = '{`CSC_OFF_ID, `CSC_OFF_INTERRUPT_CONTROL_STATE,
        `CSC_OFF_VECTOR_TABLE_OFFSET, `CSC_OFF_AUX, 8'h10};

    logic        core_clk       = 1'b0;
    logic        rst_n          = 1'b0;
    logic        hsel           = 1'b0;
    logic [31:0] haddr          = 32'h0000_0000;
    logic [1:0]  htrans         = 2'h0;
    logic        hwrite         = 1'b0;
    logic [2:0]  hsize          = 3'h2;
    logic [31:0] hwdata         = 32'h0000_0000;
    wire  logic  hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        nmiRequest     = 1'b0;
    logic        nmiEntry       = 1'b0;
    logic        pendSvEntry    = 1'b0;
    logic        tickEvent      = 1'b0;
    logic        tickEntry      = 1'b0;
    logic        anyIrqPending  = 1'b0;
    logic [6:0]  highestPending = 7'h00;
    logic        returnToBase   = 1'b0;
    logic [8:0]  activeNumber   = 9'h000;
    logic        fpInOrderForce, fpContextFlagFreeze, ifthenFoldDisable;
    logic        writeBufferDisable, multicycleIntDisable;
    logic        nmiPending, pendSvPending, tickPending, tableRegionSram;
    logic [20:0] tableBaseOffset;
    // Bench model of the register state
    logic [31:0] auxM = 32'h0000_0000;
    logic [31:0] vtM  = 32'h0000_0000;
    logic        nmiM = 1'b0, svM = 1'b0, store_multiple = 1'b0, rdPend = 1'b0;
    logic [31:0] expQ [$];
    logic [31:0] d;
    int          failures = 0, testsRun = 0;
    int          seed     = 32'h0000_78de;

    assign hready = hreadyout;
    always #5 core_clk = ~core_clk;

    csc_regs #(.ID_IMPLEMENTER(ID_EXP[31:24]), .ID_VARIANT(ID_EXP[23:20]),
        .ID_CONSTANT(ID_EXP[19:16]), .ID_PART(ID_EXP[15:4]),
        .ID_REVISION(ID_EXP[3:0])) i_csc_regs (
        .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .nmiRequest(nmiRequest), .nmiEntry(nmiEntry),
        .pendSvEntry(pendSvEntry), .tickEvent(tickEvent),
        .tickEntry(tickEntry), .anyIrqPending(anyIrqPending),
        .highestPending(highestPending), .returnToBase(returnToBase),
        .activeNumber(activeNumber), .fpInOrderForce(fpInOrderForce),
        .fpContextFlagFreeze(fpContextFlagFreeze),
        .ifthenFoldDisable(ifthenFoldDisable),
        .writeBufferDisable(writeBufferDisable),
        .multicycleIntDisable(multicycleIntDisable),
        .nmiPending(nmiPending), .pendSvPending(pendSvPending),
        .tickPending(tickPending), .tableBaseOffset(tableBaseOffset),
        .tableRegionSram(tableRegionSram));

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (failures == 0 && testsRun > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic report(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Compare of every control and pending output with the model
    task automatic chkOut();
        report({1'b0, hresp, fpInOrderForce, fpContextFlagFreeze,
            ifthenFoldDisable, writeBufferDisable, multicycleIntDisable,
            nmiPending, pendSvPending, tickPending, tableRegionSram,
            tableBaseOffset},
            {2'b00, auxM[9], auxM[8], auxM[2], auxM[1], auxM[0], nmiM, svM,
            store_multiple, vtM[29], vtM[29:9]});
    endtask

    function automatic logic [31:0] rdExp(input logic [7:0] a);
        case (a)
            `CSC_OFF_ID:   return ID_EXP;
            `CSC_OFF_INTERRUPT_CONTROL_STATE: return {nmiM, 2'b00, svM, 1'b0, store_multiple, 3'b000,
                anyIrqPending, 3'b000, highestPending, returnToBase, 2'b00,
                activeNumber};
            `CSC_OFF_VECTOR_TABLE_OFFSET: return vtM;
            `CSC_OFF_AUX:  return auxM;
            default:       return 32'h0000_0000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus master: waits are bounded so a stuck slave ends the run
    task automatic waitRdy();
        int n;
        n = 0;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                failures++;
                close_out();
            end
            @(posedge core_clk);
        end
    endtask

    task automatic addrPh(input logic [7:0] a, input logic w);
        hsel   <= 1'b1;
        haddr  <= {24'h0000_00, a};
        htrans <= 2'h2;
        hwrite <= w;
        waitRdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
    endtask

    task automatic rdc(input logic [7:0] a);
        expQ.push_back(rdExp(a));
        addrPh(a, 1'b0);
        waitRdy();
    endtask

    task automatic wrc(input logic [7:0] a, input logic [31:0] v);
        case (a)
            `CSC_OFF_AUX:  auxM = v & 32'h0000_0307;
            `CSC_OFF_VECTOR_TABLE_OFFSET: vtM = v & 32'h3FFF_FE00;
            `CSC_OFF_INTERRUPT_CONTROL_STATE: begin
                nmiM = nmiM | v[31];
                svM  = (svM & ~v[27]) | v[28];
                store_multiple  = (store_multiple & ~v[25]) | v[26];
            end
            default: ;
        endcase
        addrPh(a, 1'b1);
        hwdata <= v;
        waitRdy();
        @(posedge core_clk);
        chkOut();
    endtask

    // Core pulses: nmiRequest, nmiEntry, pendSvEntry, tickEvent, tickEntry
    task automatic evt(input logic [4:0] v);
        nmiM = (nmiM & ~v[3]) | v[4];
        svM  = svM & ~v[2];
        store_multiple  = (store_multiple & ~v[0]) | v[1];
        {nmiRequest, nmiEntry, pendSvEntry, tickEvent, tickEntry} <= v;
        @(posedge core_clk);
        {nmiRequest, nmiEntry, pendSvEntry, tickEvent, tickEntry} <= 5'h00;
        @(posedge core_clk);
        chkOut();
        rdc(`CSC_OFF_INTERRUPT_CONTROL_STATE);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Read data arrives when hreadyout returns after a taken read
    always @(posedge core_clk) begin
        if (!rst_n)
            rdPend = 1'b0;
        else begin
            if (rdPend && hreadyout === 1'b1) begin
                rdPend = 1'b0;
                report(hrdata, expQ.pop_front());
            end
            if (hsel && htrans[1] && hreadyout === 1'b1 && !hwrite)
                rdPend = 1'b1;
        end
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        failures++;
        close_out();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        chkOut();
        foreach (REGS[i]) rdc(REGS[i]);
        foreach (REGS[i]) if (REGS[i] != `CSC_OFF_INTERRUPT_CONTROL_STATE)
            wrc(REGS[i], 32'hFFFF_FFFF);
        foreach (REGS[i]) rdc(REGS[i]);
        for (int b = 0; b < 12; b++) begin
            wrc(`CSC_OFF_AUX, 32'h0000_0001 << b);
            rdc(`CSC_OFF_AUX);
        end
        repeat (4) begin
            d = $random(seed) & 32'hFFFF_FE00;
            wrc(`CSC_OFF_VECTOR_TABLE_OFFSET, d);
            rdc(`CSC_OFF_VECTOR_TABLE_OFFSET);
        end
        wrc(`CSC_OFF_INTERRUPT_CONTROL_STATE, 32'h1000_0000);
        wrc(`CSC_OFF_INTERRUPT_CONTROL_STATE, 32'h0000_0000);
        rdc(`CSC_OFF_INTERRUPT_CONTROL_STATE);
        wrc(`CSC_OFF_INTERRUPT_CONTROL_STATE, 32'h0800_0000);
        wrc(`CSC_OFF_INTERRUPT_CONTROL_STATE, 32'h0400_0000);
        rdc(`CSC_OFF_INTERRUPT_CONTROL_STATE);
        wrc(`CSC_OFF_INTERRUPT_CONTROL_STATE, 32'h0200_0000);
        wrc(`CSC_OFF_INTERRUPT_CONTROL_STATE, 32'h8000_0000);
        rdc(`CSC_OFF_INTERRUPT_CONTROL_STATE);
        evt(5'b01000);
        evt(5'b10000);
        evt(5'b01010);
        wrc(`CSC_OFF_INTERRUPT_CONTROL_STATE, 32'h1000_0000);
        evt(5'b00101);
        evt(5'b11000);
        evt(5'b00011);
        repeat (8) begin
            d = $random(seed);
            if (d[28] && d[27])
                d[27] = 1'b0;
            if (d[26] && d[25])
                d[25] = 1'b0;
            anyIrqPending  <= 1'($random(seed));
            highestPending <= 7'($random(seed));
            returnToBase   <= 1'($random(seed));
            activeNumber   <= 9'($random(seed));
            wrc(`CSC_OFF_INTERRUPT_CONTROL_STATE, d);
            rdc(`CSC_OFF_INTERRUPT_CONTROL_STATE);
        end
        repeat (2) @(posedge core_clk);
        close_out();
    end
endmodule

`default_nettype wire
